// File: hw/ncp_params.svh
// constants of the coprocessor host port: pin commands, reset timing,
// operand burst sizes and the register map of the local Avalon slave.
// assumes inclusion by bare name from the design files.
`ifndef NCP_PARAMS_SVH
`define NCP_PARAMS_SVH

// ****************************************
// pin side
// ****************************************
`define NCP_DATA_W 16
`define NCP_INIT_CYCLES 5'h19
`define NCP_CMD_WORD 2'h0
`define NCP_CMD_DATA 2'h1
`define NCP_CMD_EXC 2'h2
`define NCP_LONG_XFER 3'h5
`define NCP_FIRST_BURST 3'h3
`define NCP_NEXT_BURST 3'h4
`define NCP_SW_ES 4'h7

// ****************************************
// register map: byte offsets, control finish bit and status word reset value
// ****************************************
`define NCP_OFS_STATUS 5'h00
`define NCP_OFS_OPCODE 5'h04
`define NCP_OFS_DATA_IN 5'h08
`define NCP_OFS_DATA_OUT 5'h0c
`define NCP_OFS_STATUS_WORD 5'h10
`define NCP_OFS_CONTROL 5'h14
`define NCP_OFS_EXC_PTR 5'h18
`define NCP_CTL_FINISH 5'h10
`define NCP_SW_RESET 16'h0000

`endif

// File: hw/ncp_pkg.sv
// types shared by the coprocessor host port.
// assumes nothing of its surroundings.
package ncp_pkg;

  typedef enum logic [2:0]
  {
    ncp_init = 3'b001,
    ncp_idle = 3'b010,
    ncp_exec = 3'b100
  } ncp_state_t;

endpackage

// File: hw/ncp_host_port.sv
// coprocessor host port: pin handshake, reset sequence, strobes and selects,
// plus an Avalon-MM slave through which the internal sequencer steers it.
// assumes host pins are asynchronous to clk and the host keeps its own rules.
//
// Overview of operation
// - strap high runs timing on every clock, strap low on every second clock.
// - reset rise abandons all activity and parks the port dormant.
// - after reset falls, internal initialisation runs 25 internal clocks.
// - during reset busy and error are high, request low, data undriven.
// - after reset every output returns to its inactive level.
// - request rises when the sequencer writes a transfer count, may fall after acknowledge.
// - request falls once all operands of the instruction moved.
// - beyond five transfers, request drops after three then every four.
// - request always goes inactive before busy goes inactive.
// - busy low while executing, high throughout the reset sequence.
// - error pin mirrors error summary bit of the status word, low active.
// - error returns inactive only through the listed no-wait instructions; here through any instruction once the status bit is clear.
// - error pin changes level only while busy is active.
// - acknowledge is asynchronous and synchronised inside the port.
// - sixteen-bit data bus, high is one, bit zero least significant.
// - write strobe moves host data in only while both selects active.
// - read strobe drives data out only during a selected read.
// - command 00 opcode or word, bit0 operand data, bit1 write pointers.
// - no transfer at all unless both selects are asserted together.
// - busy asserts as soon as an opcode write is recognised.
`include "ncp_params.svh"
`timescale 1ns/1ps
`default_nettype none

module ncp_host_port
  import ncp_pkg::*;
#(
  parameter int XFER_W = 16
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // coprocessor pins
  input wire logic clock_divide_strap,
  input wire logic operand_acknowledge_n,
  input wire logic coproc_read_strobe_n,
  input wire logic coproc_write_strobe_n,
  input wire logic select_active_low_n,
  input wire logic select_active_high,
  input wire logic command_bit_zero,
  input wire logic command_bit_one,
  input wire logic [`NCP_DATA_W-1:0] data_in,
  output logic [`NCP_DATA_W-1:0] data_out,
  output logic data_oe_n,
  output logic operand_request,
  output logic busy_n,
  output logic error_n,
  // avalon-mm slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  localparam int PIN_W = 8 + `NCP_DATA_W;
  localparam logic [PIN_W-1:0] PIN_IDLE = {6'h3e, 2'h0, 16'h0000};

  if (XFER_W < 3 || XFER_W > 16)
  begin : g_check
    $error("ncp_host_port: XFER_W must lie in 3..16");
  end

  function automatic logic [2:0] burst_len(input logic [XFER_W-1:0] n, input logic first);
    logic [2:0] len;
    len = n[2:0];
    if (first && n > XFER_W'(`NCP_LONG_XFER))
      len = `NCP_FIRST_BURST;
    else if (!first && n > XFER_W'(`NCP_NEXT_BURST))
      len = `NCP_NEXT_BURST;
    return len;
  endfunction

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        res[i*8 +: 8] = nw[i*8 +: 8];
    return res;
  endfunction

  // ****************************************
  // pin synchronisers
  // ****************************************
  // three stages; a bit moves only when stages two and three agree
  logic [PIN_W-1:0] s1, s2, s3, flt, prev;
  wire [PIN_W-1:0] pins = {clock_divide_strap, operand_acknowledge_n, coproc_read_strobe_n,
                           coproc_write_strobe_n, select_active_low_n, select_active_high,
                           command_bit_one, command_bit_zero, data_in};

  // left without reset so that the strap has settled by release
  always_ff @(posedge clk)
  begin
    s1 <= pins;
    s2 <= s1;
    s3 <= s2;
    flt <= (s3 & ~(s2 ^ s3)) | (flt & (s2 ^ s3));
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      prev <= PIN_IDLE;
    else
      prev <= flt;
  end

  logic f_strap, f_ack_n, f_rd_n, f_wr_n, f_sel_n, f_sel;
  logic [1:0] f_cmd;
  logic [`NCP_DATA_W-1:0] f_data;
  logic p_strap, p_ack_n, p_rd_n, p_wr_n, p_sel_n, p_sel;
  logic [1:0] p_cmd;
  logic [`NCP_DATA_W-1:0] p_data;
  assign {f_strap, f_ack_n, f_rd_n, f_wr_n, f_sel_n, f_sel, f_cmd, f_data} = flt;
  assign {p_strap, p_ack_n, p_rd_n, p_wr_n, p_sel_n, p_sel, p_cmd, p_data} = prev;

  // ****************************************
  // host cycle decode
  // ****************************************
  ncp_state_t state, next_state;
  logic [XFER_W-1:0] remaining, next_remaining;
  logic [2:0] burst, next_burst;
  logic [4:0] init_cnt;
  logic strap_direct, tick, init_first, finish_pend;
  logic [`NCP_DATA_W-1:0] opcode_reg, data_in_reg, data_out_reg, status_word, exc_ptr;
  logic opcode_new, data_new;

  wire sel_now = ~f_sel_n & f_sel;
  wire sel_prev = ~p_sel_n & p_sel;
  // transfers count on the trailing strobe edge, data from the cycle before
  wire host_wr = sel_prev & ~p_wr_n & f_wr_n;
  wire host_rd_end = sel_prev & ~p_rd_n & f_rd_n;
  wire wr_opcode = host_wr & (p_cmd == `NCP_CMD_WORD) & (state != ncp_init);
  wire wr_data = host_wr & (p_cmd == `NCP_CMD_DATA);
  wire wr_exc = host_wr & (p_cmd == `NCP_CMD_EXC);
  wire rd_data_end = host_rd_end & (p_cmd == `NCP_CMD_DATA);
  wire rd_valid = sel_now & ~f_rd_n & ((f_cmd == `NCP_CMD_WORD) | (f_cmd == `NCP_CMD_DATA));
  wire xfer_done = (wr_data | rd_data_end) & (state == ncp_exec) & (remaining != '0);

  // ****************************************
  // avalon decode
  // ****************************************
  wire av_req = avs_read | avs_write;
  wire av_take = av_req & ~avs_waitrequest;
  wire [4:0] av_ofs = {avs_address[4:2], 2'h0};
  wire av_wr = av_take & avs_write;
  wire av_rd = av_take & avs_read;
  wire wr_ctl = av_wr & (av_ofs == `NCP_OFS_CONTROL);
  wire [31:0] ctl_val = be_merge(32'h0, avs_writedata, avs_byteenable);
  wire [XFER_W-1:0] ctl_count = ctl_val[XFER_W-1:0];
  wire ctl_start = wr_ctl & (ctl_count != '0) & (state == ncp_exec) & (remaining == '0);
  wire ctl_finish = wr_ctl & ctl_val[`NCP_CTL_FINISH];
  wire [31:0] dout_merge = be_merge({16'h0, data_out_reg}, avs_writedata, avs_byteenable);
  wire [31:0] sw_merge = be_merge({16'h0, status_word}, avs_writedata, avs_byteenable);
  wire [31:0] rd_mux =
    (av_ofs == `NCP_OFS_STATUS) ? {{(16-XFER_W){1'b0}}, remaining, 8'h0, strap_direct,
                                   state == ncp_init, ~f_ack_n, data_new, opcode_new,
                                   ~error_n, operand_request, state == ncp_exec} :
    (av_ofs == `NCP_OFS_OPCODE) ? {16'h0, opcode_reg} :
    (av_ofs == `NCP_OFS_DATA_IN) ? {16'h0, data_in_reg} :
    (av_ofs == `NCP_OFS_DATA_OUT) ? {16'h0, data_out_reg} :
    (av_ofs == `NCP_OFS_STATUS_WORD) ? {16'h0, status_word} :
    (av_ofs == `NCP_OFS_EXC_PTR) ? {16'h0, exc_ptr} : 32'h0;

  // ****************************************
  // sequencing
  // ****************************************
  always_comb
  begin
    next_state = state;
    unique case (state)
      ncp_init:
        if (init_cnt == '0)
          next_state = ncp_idle;
      ncp_idle:
        if (wr_opcode)
          next_state = ncp_exec;
      ncp_exec:
        if (finish_pend & ~operand_request & (remaining == '0))
          next_state = ncp_idle;
    endcase
  end

  always_comb
  begin
    next_remaining = remaining;
    next_burst = burst;
    if (ctl_start)
    begin
      next_remaining = ctl_count;
      next_burst = burst_len(ctl_count, 1'b1);
    end
    else if (xfer_done)
    begin
      next_remaining = remaining - XFER_W'(1);
      next_burst = burst - 3'h1;
    end
    else if (burst == '0 && remaining != '0)
      next_burst = burst_len(remaining, 1'b0);
  end

  // a request gap of at least two cycles separates bursts; early drop once the last is acknowledged
  wire next_req = (next_state == ncp_exec) & (next_remaining != '0) & (next_burst != '0)
                  & ~(burst == '0) & ~((next_burst == 3'h1) & ~f_ack_n);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state <= ncp_init;
      init_cnt <= `NCP_INIT_CYCLES;
      init_first <= 1'b1;
      strap_direct <= 1'b1;
      tick <= 1'b0;
    end
    else
    begin
      state <= next_state;
      init_first <= 1'b0;
      if (init_first)
        strap_direct <= f_strap;
      tick <= strap_direct | ~tick;
      if (state == ncp_init && tick && init_cnt != '0)
        init_cnt <= init_cnt - 5'h1;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      remaining <= '0;
      burst <= '0;
      finish_pend <= 1'b0;
    end
    else
    begin
      remaining <= next_remaining;
      burst <= next_burst;
      finish_pend <= (state == ncp_exec) & (finish_pend | ctl_finish) & (next_state == ncp_exec);
    end
  end

  // ****************************************
  // pin outputs
  // ****************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      operand_request <= 1'b0;
      busy_n <= 1'b1;
      error_n <= 1'b1;
      data_oe_n <= 1'b1;
      data_out <= '0;
    end
    else
    begin
      operand_request <= next_req;
      busy_n <= ~(next_state == ncp_exec);
      // error may only move while busy is already low
      if (state == ncp_exec && !busy_n)
        error_n <= ~status_word[`NCP_SW_ES];
      data_oe_n <= ~rd_valid;
      data_out <= (f_cmd == `NCP_CMD_WORD) ? status_word : data_out_reg;
    end
  end

  // ****************************************
  // host and software registers
  // ****************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      opcode_reg <= '0;
      data_in_reg <= '0;
      exc_ptr <= '0;
      opcode_new <= 1'b0;
      data_new <= 1'b0;
    end
    else
    begin
      if (wr_opcode)
        opcode_reg <= p_data;
      if (wr_data)
        data_in_reg <= p_data;
      if (wr_exc)
        exc_ptr <= p_data;
      // a fresh host write wins over a read that clears the flag
      opcode_new <= wr_opcode | (opcode_new & ~(av_rd & (av_ofs == `NCP_OFS_OPCODE)));
      data_new <= wr_data | (data_new & ~(av_rd & (av_ofs == `NCP_OFS_DATA_IN)));
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      data_out_reg <= '0;
      status_word <= `NCP_SW_RESET;
    end
    else if (av_wr)
    begin
      if (av_ofs == `NCP_OFS_DATA_OUT)
        data_out_reg <= dout_merge[15:0];
      if (av_ofs == `NCP_OFS_STATUS_WORD)
        status_word <= sw_merge[15:0];
    end
  end

  // one wait state on every access, read data registered in that cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
    end
    else
    begin
      avs_waitrequest <= ~(av_req & avs_waitrequest);
      if (avs_read & avs_waitrequest)
        avs_readdata <= rd_mux;
    end
  end

endmodule

`default_nettype wire

// File: verif/ncp_host_port_chk.sv
// assertions on the coprocessor pins of the host port.
// assumes a bind into ncp_host_port, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module ncp_host_port_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // host pins
  input wire logic coproc_read_strobe_n,
  input wire logic coproc_write_strobe_n,
  input wire logic select_active_low_n,
  input wire logic select_active_high,
  input wire logic command_bit_zero,
  input wire logic command_bit_one,
  // port outputs
  input wire logic data_oe_n,
  input wire logic operand_request,
  input wire logic busy_n,
  input wire logic error_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [2:0] burst_cnt;
  wire logic sel = !select_active_low_n && select_active_high;
  // raw strobe edges, so the filter delay cannot hide a fifth transfer
  always_ff @(posedge clk or posedge rst)
    if (rst)
      burst_cnt <= 3'h0;
    else if (!operand_request)
      burst_cnt <= 3'h0;
    else if (sel && command_bit_zero && $rose(coproc_write_strobe_n))
      burst_cnt <= burst_cnt + 3'h1;
  property p_quiet; $fell(rst) |-> (busy_n && error_n && !operand_request && data_oe_n) [*8]; endproperty
  a_quiet: assert property (p_quiet) else $error("output active after reset");
  property p_req_first; $rose(busy_n) |-> $past(!operand_request); endproperty
  a_req_first: assert property (p_req_first) else $error("busy ended before request");
  property p_err_busy; $changed(error_n) |-> $past(!busy_n); endproperty
  a_err_busy: assert property (p_err_busy) else $error("error moved while idle");
  property p_oe_sel; $fell(data_oe_n) |-> $past(sel && !coproc_read_strobe_n && !command_bit_one, 2); endproperty
  a_oe_sel: assert property (p_oe_sel) else $error("bus driven without read");
  property p_oe_rel; coproc_read_strobe_n [*6] |-> data_oe_n; endproperty
  a_oe_rel: assert property (p_oe_rel) else $error("bus held after read");
  property p_busy_op; sel && !command_bit_zero && !command_bit_one && $rose(coproc_write_strobe_n) |-> ##[1:8] !busy_n;
  endproperty
  a_busy_op: assert property (p_busy_op) else $error("no busy after opcode");
  property p_burst; operand_request |-> burst_cnt <= 3'h4; endproperty
  a_burst: assert property (p_burst) else $error("burst too long");
  property p_req_exec; operand_request |-> !busy_n; endproperty
  a_req_exec: assert property (p_req_exec) else $error("request while idle");
  c_gap: cover property (operand_request ##1 !operand_request ##1 operand_request);
  c_read: cover property ($fell(data_oe_n));
  c_err: cover property ($fell(error_n));
endmodule
bind ncp_host_port ncp_host_port_chk chk (.clk, .rst, .coproc_read_strobe_n, .coproc_write_strobe_n,
  .select_active_low_n, .select_active_high, .command_bit_zero, .command_bit_one, .data_oe_n,
  .operand_request, .busy_n, .error_n);
`default_nettype wire

// File: verif/ncp_host_model.sv
// host cpu model: strobes, selects, command, acknowledge and its bus half.
// assumes the bench calls cyc and shares clk with the port.
`timescale 1ns/1ps
`default_nettype none
module ncp_host_model (
  // clock
  input wire logic clk,
  // from the port
  input wire logic req,
  input wire logic oe_n,
  input wire logic [15:0] dout,
  // to the port
  output logic ack_n,
  output logic rd_n,
  output logic wr_n,
  output logic sel_n,
  output logic sel,
  output logic c0,
  output logic c1,
  output logic [15:0] din
);
  logic drv = 1'b0;
  logic ack_en = 1'b0;
  logic [15:0] hdat = 16'h0;
  int xfers = 0;
  // released bus shows the inverse of the last value, never a stale copy
  assign din = !oe_n ? dout : drv ? hdat : ~hdat;
  initial
  begin
    {ack_n, rd_n, wr_n, sel_n} = 4'hf;
    {sel, c0, c1} = 3'h0;
  end
  // 6 clk each way, well past the input filter
  task cyc(input logic r, input logic [1:0] c, input logic [15:0] d, input logic [1:0] s, output logic [15:0] q);
    @(posedge clk);
    {sel_n, sel} <= {!s[1], s[0]};
    {c1, c0} <= c;
    hdat <= d;
    drv <= !r;
    @(posedge clk);
    {rd_n, wr_n} <= {!r, r};
    ack_n <= !(ack_en && c[0] && req);
    xfers += c[0];
    repeat (6) @(posedge clk);
    q = din;
    {rd_n, wr_n, ack_n} <= 3'h7;
    repeat (6) @(posedge clk);
    {sel_n, sel, drv} <= 3'h4;
  endtask
endmodule
`default_nettype wire

// File: verif/numeric_coprocessor_host_port_tb_top.sv
// bench for the coprocessor host port, pins and registers.
// assumes the host model and checker files compile first.
`include "ncp_params.svh"
`timescale 1ns/1ps
`default_nettype none
module numeric_coprocessor_host_port_tb_top;
  logic clk = 0, rst = 0, strap = 1, ard = 0, awr = 0, oe_seen = 0, prev_req = 0;
  logic [4:0] aa = 5'h0;
  logic [31:0] awd = 32'h0, aq;
  logic [15:0] hq;
  wire logic ack_n, rd_n, wr_n, sel_n, sel, c0, c1, oe_n, req, busy_n, err_n, wreq;
  wire logic [15:0] din, dout;
  wire logic [31:0] rdata;
  int mismatches = 0, n_checks = 0, last = 0;
  int bursts[$];
  always #2 clk = ~clk;
  ncp_host_port dut (.clk(clk), .rst(rst), .clock_divide_strap(strap), .operand_acknowledge_n(ack_n),
    .coproc_read_strobe_n(rd_n), .coproc_write_strobe_n(wr_n), .select_active_low_n(sel_n),
    .select_active_high(sel), .command_bit_zero(c0), .command_bit_one(c1), .data_in(din), .data_out(dout),
    .data_oe_n(oe_n), .operand_request(req), .busy_n(busy_n), .error_n(err_n), .avs_address(aa),
    .avs_read(ard), .avs_write(awr), .avs_writedata(awd), .avs_byteenable(4'hf), .avs_readdata(rdata),
    .avs_waitrequest(wreq));
  ncp_host_model host (.clk, .req, .oe_n, .dout, .ack_n, .rd_n, .wr_n, .sel_n, .sel, .c0, .c1, .din);
  always @(posedge clk)
  begin
    oe_seen |= oe_n === 1'b0;
    if (prev_req && !req)
    begin
      bursts.push_back(host.xfers - last);
      last = host.xfers;
    end
    prev_req = req;
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task note(input string s);
    $display("end of %s, mismatches %0d", s, mismatches);
  endtask
  task av(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {aa, awd, awr, ard} <= {a, d, w, !w};
    @(posedge clk);
    while (wreq !== 1'b0 && n++ < 99)
      @(posedge clk);
    if (wreq !== 1'b0)
      mismatches++;
    aq = rdata;
    {awr, ard} <= 2'h0;
  endtask
  task rdc(input logic [4:0] a, input logic [31:0] e);
    av(0, a, 0);
    chk(aq, e);
  endtask
  task opc;
    host.cyc(0, 2'h0, 16'hdbe3, 2'h3, hq);
    repeat (2) @(posedge clk);
  endtask
  task fin;
    int n;
    n = 0;
    av(1, `NCP_OFS_CONTROL, 32'h1 << `NCP_CTL_FINISH);
    while (busy_n !== 1'b1 && n++ < 99)
      @(posedge clk);
    if (busy_n !== 1'b1)
      mismatches++;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task t_strap(input logic s);
    @(posedge clk);
    strap <= s;
    repeat (8) @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    chk({busy_n, err_n, req, oe_n}, 4'hd);
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (35) @(posedge clk);
    av(0, `NCP_OFS_STATUS, 0);
    chk(aq[7:6], {s, !s});
    repeat (30) @(posedge clk);
    av(0, `NCP_OFS_STATUS, 0);
    chk(aq[7:6], {s, 1'b0});
    rdc(`NCP_OFS_STATUS_WORD, `NCP_SW_RESET);
    rdc(5'h1c, 0);
    note("strap");
  endtask
  task t_opc;
    opc;
    chk(busy_n, 0);
    rdc(`NCP_OFS_OPCODE, 32'hdbe3);
    note("opcode");
  endtask
  task t_sel;
    logic [4:0] v[7] = '{5'h01, 5'h02, 5'h15, 5'h16, 5'h1b, 5'h1f, 5'h0f};
    logic [31:0] o;
    av(0, `NCP_OFS_OPCODE, 0);
    o = aq;
    oe_seen = 0;
    foreach (v[i])
      host.cyc(v[i][4], v[i][3:2], 16'h5a5a, v[i][1:0], hq);
    chk(oe_seen, 0);
    chk(busy_n, 1);
    rdc(`NCP_OFS_OPCODE, o);
    note("select");
  endtask
  task t_rd;
    opc;
    av(1, `NCP_OFS_DATA_OUT, 32'ha55a);
    av(1, `NCP_OFS_STATUS_WORD, 32'h41);
    host.cyc(1, 2'h1, 16'h0, 2'h3, hq);
    chk(hq, 16'ha55a);
    host.cyc(1, 2'h0, 16'h0, 2'h3, hq);
    chk(hq, 16'h41);
    host.cyc(0, 2'h2, 16'h8421, 2'h3, hq);
    rdc(`NCP_OFS_EXC_PTR, 32'h8421);
    fin;
    note("read");
  endtask
  task t_xfer(input int n, input logic a);
    int k, w, r, b;
    opc;
    host.ack_en = a;
    bursts.delete();
    last = host.xfers;
    av(1, `NCP_OFS_CONTROL, n);
    for (k = 0; k < n; k++)
    begin
      w = 0;
      while (req !== 1'b1 && w++ < 99)
        @(posedge clk);
      if (req !== 1'b1)
        mismatches++;
      host.cyc(0, 2'h1, {1'b1, k[14:0]}, 2'h3, hq);
    end
    repeat (4) @(posedge clk);
    chk(req, 0);
    r = n;
    b = n > 5 ? 3 : n;
    for (k = 0; r > 0; k++)
    begin
      chk(bursts[k], b < r ? b : r);
      r = r - b;
      b = 4;
    end
    chk(bursts.size(), k);
    rdc(`NCP_OFS_DATA_IN, 32'h7fff + n);
    fin;
    chk(busy_n, 1);
    host.ack_en = 0;
    note("transfer");
  endtask
  task t_err;
    opc;
    av(1, `NCP_OFS_STATUS_WORD, 32'h1 << `NCP_SW_ES);
    repeat (4) @(posedge clk);
    chk(err_n, 0);
    fin;
    av(1, `NCP_OFS_STATUS_WORD, 0);
    repeat (4) @(posedge clk);
    chk(err_n, 0);
    opc;
    repeat (4) @(posedge clk);
    chk(err_n, 1);
    fin;
    note("error");
  endtask
  task finish_test;
    $display("checks %0d, mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_strap(0);
    t_opc;
    t_strap(1);
    t_sel;
    t_rd;
    t_xfer(7, 0);
    t_xfer(5, 1);
    t_xfer(10, 1);
    t_err;
    finish_test;
  end
  // tests need some 1k clk; fifty times that means a hang
  initial
  begin
    #200000;
    mismatches++;
    finish_test;
  end
endmodule
`default_nettype wire
